// *** rtl/speech_rom_cfg.svh ***
// Constants for the speech memory card address and decode logic
// Assumes inclusion by the package and the design modules
`ifndef SPEECH_ROM_CFG_SVH
`define SPEECH_ROM_CFG_SVH
`define BUS_W          8
`define ADDR_W         20
`define HIGH_W         4
`define MED_W          8
`define LOW_W          8
`define ADDR_HI_LSB    16
`define ADDR_MED_LSB   8
`define ROM_TOP        20'h3_FFFF
`define VCARD_BIT      17
`define ROW_MSB        16
`define ROW_LSB        15
`define COL_MSB        14
`define COL_LSB        14
`define NUM_ROWS       4
`define NUM_COLS       2
`define LATCH_RST_HI   4'h0
`define LATCH_RST_MED  8'h00
`define SYNC_RST       3'h0
`define TONE_HZ        760
`define TONE_DBM       (-13)
`define TONE_MS        160
`define DIGIT_MS       1000
`define PHRASE_TONE    8'h01
`define PHRASE_DIG0    8'h04
`define PHRASE_DIG9    8'h0D
`endif

// *** rtl/speech_rom_pkg.sv ***
// Types for the speech memory card address and decode logic
// Assumes the cfg header is on the include path
`include "speech_rom_cfg.svh"
package speech_rom_pkg;
	typedef enum logic [1:0] {
		cyc_idle   = 2'b00,
		cyc_high   = 2'b01,
		cyc_medium = 2'b10,
		cyc_data   = 2'b11
	} bus_cycle_t;
	typedef logic [`ADDR_W-1:0] mem_addr_t;
	typedef logic [`BUS_W-1:0]  bus_byte_t;
endpackage

// *** rtl/decode_if.sv ***
// Interface carrying the assembled address and the decoded enables
// Assumes the package is compiled first
`timescale 1ns/1ps
`include "speech_rom_cfg.svh"
interface decode_if;
	import speech_rom_pkg::*;
	mem_addr_t              addr;
	logic                   strobe;
	logic                   card_en;
	logic [`NUM_ROWS-1:0]   chip_en;
	logic [`NUM_COLS-1:0]   out_en;
	logic [`NUM_ROWS-1:0]   write_en;
	logic                   data_en;
	modport top (output addr, output strobe, input card_en, input chip_en,
		input out_en, input write_en, input data_en);
	modport dec (input addr, input strobe, output card_en, output chip_en,
		output out_en, output write_en, output data_en);
endinterface

// *** rtl/address_decoder.sv ***
// Lookup decoder for card, chip, output and write enables
// Assumes an address already assembled and a synchronised strobe
`timescale 1ns/1ps
`include "speech_rom_cfg.svh"
module address_decoder (
	decode_if.dec dif
);
	import speech_rom_pkg::*;
	function automatic logic [`NUM_ROWS-1:0] one_hot4(input logic [1:0] sel);
		one_hot4 = {{(`NUM_ROWS-1){1'b0}}, 1'b1} << sel;
	endfunction
	function automatic logic [`NUM_COLS-1:0] one_hot2(input logic sel);
		one_hot2 = {{(`NUM_COLS-1){1'b0}}, 1'b1} << sel;
	endfunction
	logic in_range;
	always_comb begin
		in_range = (dif.addr <= `ROM_TOP); // RQ6
		dif.card_en = in_range; // RQ6
		dif.chip_en = in_range ? one_hot4(dif.addr[`ROW_MSB:`ROW_LSB]) : '0; // RQ5 RQ7
		dif.out_en = (in_range && dif.strobe) ?
			one_hot2(dif.addr[`COL_MSB]) : '0; // RQ7
		dif.write_en = '0; // RQ5
		dif.data_en = in_range && dif.strobe; // RQ8
	end
endmodule // address_decoder

// *** rtl/speech_rom_address_mux.sv ***
// Address assembly and memory access for the double-density speech card
// Assumes a controller on the same clock drives the bus; strobe comes from a pin
//
// Summary of operation
// RQ1 - A 20-bit memory address is built from successive 8-bit bus transfers.
// RQ2 - The top address part is held in a high latch until overwritten.
// RQ3 - The middle address part is held in its own medium latch.
// RQ4 - The low address byte comes straight from the bus, unlatched.
// RQ5 - A lookup decoder yields card decode, chip enables and write enables.
// RQ6 - Card enable is set only while the address lies in the memory range.
// RQ7 - Column decode drives output enables, row decode drives chip enables.
// RQ8 - Memory data reaches the bus only while the controller's strobe is active; the code drives until the fifth clock after the pin falls.
// RQ9 - The card holds 256 Kbytes split into virtual cards zero and one.
// RQ10 - The card identity comes from a three-position switch set before use.
// RQ11 - Phrase one of card zero is a 760 Hz, -13 dBm test tone of 0.160 s.
// RQ12 - Phrases four to thirteen of card zero are digits zero to nine, 1.0 s each.
// RQ13 - Phrase length counts leading and trailing silence blocks.
// RQ14 - The controller loads high and medium latches before the strobed access.
`timescale 1ns/1ps
`include "speech_rom_cfg.svh"
module speech_rom_address_mux (
	input  wire logic                      sys_clk,
	input  wire logic                      sys_rst,
	input  wire speech_rom_pkg::bus_byte_t bus_in,
	input  wire logic                      load_high,
	input  wire logic                      load_medium,
	input  wire logic                      data_strobe_pin,
	input  wire logic [2:0]                card_switch,
	input  wire speech_rom_pkg::bus_byte_t mem_data,
	output speech_rom_pkg::bus_byte_t      bus_out,
	output logic                           bus_out_en_n,
	output speech_rom_pkg::mem_addr_t      mem_addr,
	output logic                           card_en,
	output logic [`NUM_ROWS-1:0]           chip_en,
	output logic [`NUM_COLS-1:0]           out_en,
	output logic [`NUM_ROWS-1:0]           write_en,
	output logic                           virtual_card,
	output logic [2:0]                     card_id,
	output speech_rom_pkg::bus_cycle_t     last_cycle
);
	import speech_rom_pkg::*;
	// ----------------------------------------------------------------
	// Address latches
	// ----------------------------------------------------------------
	logic [`HIGH_W-1:0] high_latch;
	logic [`HIGH_W-1:0] next_high_latch;
	logic [`MED_W-1:0]  med_latch;
	logic [`MED_W-1:0]  next_med_latch;
	always_comb begin
		next_high_latch = high_latch;
		next_med_latch = med_latch;
		if (load_high)
			next_high_latch = bus_in[`HIGH_W-1:0]; // RQ1 RQ2
		if (load_medium)
			next_med_latch = bus_in; // RQ1 RQ3
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			high_latch <= `LATCH_RST_HI;
			med_latch <= `LATCH_RST_MED;
		end else begin
			high_latch <= next_high_latch;
			med_latch <= next_med_latch;
		end
	end
	// ----------------------------------------------------------------
	// Strobe and switch synchronisers
	// ----------------------------------------------------------------
	logic [2:0] strobe_sync;
	logic [2:0] next_strobe_sync;
	logic       strobe;
	logic       next_strobe;
	logic [2:0] sw_a;
	logic [2:0] sw_b;
	logic [2:0] sw_c;
	logic [2:0] next_card_id;
	always_comb begin
		next_strobe_sync = {strobe_sync[1:0], data_strobe_pin};
		next_strobe = (strobe_sync[1] == strobe_sync[2]) ? strobe_sync[2] : strobe;
		next_card_id = (sw_b == sw_c) ? sw_c : card_id; // RQ10
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			strobe_sync <= `SYNC_RST;
			strobe <= 1'b0;
			sw_a <= `SYNC_RST;
			sw_b <= `SYNC_RST;
			sw_c <= `SYNC_RST;
			card_id <= `SYNC_RST;
		end else begin
			strobe_sync <= next_strobe_sync;
			strobe <= next_strobe;
			sw_a <= card_switch;
			sw_b <= sw_a;
			sw_c <= sw_b;
			card_id <= next_card_id;
		end
	end
	// ----------------------------------------------------------------
	// Address assembly and decode
	// ----------------------------------------------------------------
	decode_if dif ();
	always_comb begin
		dif.addr = {high_latch, med_latch, bus_in}; // RQ1 RQ4 RQ14
		dif.strobe = strobe; // RQ8
	end
	address_decoder u_dec (
		.dif (dif)
	);
	// ----------------------------------------------------------------
	// Registered bus and cycle outputs, combinational decode outputs
	// ----------------------------------------------------------------
	bus_byte_t  next_bus_out;
	logic       next_bus_out_en_n;
	bus_cycle_t next_last_cycle;
	always_comb begin
		next_bus_out = dif.data_en ? mem_data : bus_out; // RQ8
		next_bus_out_en_n = ~dif.data_en; // RQ8
		if (load_high)
			next_last_cycle = cyc_high;
		else if (load_medium)
			next_last_cycle = cyc_medium;
		else if (dif.data_en)
			next_last_cycle = cyc_data;
		else
			next_last_cycle = last_cycle;
	end
	always_ff @(posedge sys_clk or posedge sys_rst) begin
		if (sys_rst) begin
			bus_out <= '0;
			bus_out_en_n <= 1'b1;
			last_cycle <= cyc_idle;
		end else begin
			bus_out <= next_bus_out;
			bus_out_en_n <= next_bus_out_en_n;
			last_cycle <= next_last_cycle;
		end
	end
	always_comb begin
		mem_addr = dif.addr;
		card_en = dif.card_en; // RQ6
		chip_en = dif.chip_en; // RQ7
		out_en = dif.out_en; // RQ7
		write_en = dif.write_en; // RQ5
		virtual_card = dif.addr[`VCARD_BIT]; // RQ9
	end
	// Phrase content (RQ11 RQ12 RQ13) lives in the memory image, not in logic.
endmodule // speech_rom_address_mux

// *** verif/speech_rom_assertions.sv ***
// Port checker for the speech card address logic
// Assumes a bind to the top module
`timescale 1ns/1ps
module speech_rom_checker import speech_rom_pkg::*; (
	input wire logic       sys_clk,
	input wire logic       sys_rst,
	input wire bus_byte_t  bus_in,
	input wire logic       load_high,
	input wire logic       load_medium,
	input wire logic       data_strobe_pin,
	input wire logic       bus_out_en_n,
	input wire mem_addr_t  mem_addr,
	input wire logic       card_en,
	input wire logic [3:0] chip_en,
	input wire logic [1:0] out_en
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	sequence s_quiet; !data_strobe_pin [*6]; endsequence
	a_low_byte: assert property (mem_addr[7:0] == bus_in)
		else $error("low byte wrong");
	a_high_load: assert property (load_high |=> mem_addr[19:16] == $past(bus_in[3:0]))
		else $error("high latch wrong");
	a_high_hold: assert property (!load_high |=> $stable(mem_addr[19:16]))
		else $error("high latch moved");
	a_med_load: assert property (load_medium |=> mem_addr[15:8] == $past(bus_in))
		else $error("medium latch wrong");
	a_card_range: assert property (card_en == (mem_addr <= 20'h3_FFFF))
		else $error("card enable wrong");
	a_row_chip: assert property (chip_en == (card_en ? 4'h1 << mem_addr[16:15] : 4'h0))
		else $error("chip enable wrong");
	a_col_out: assert property (|out_en |-> card_en && out_en == 2'h1 << mem_addr[14])
		else $error("output enable wrong");
	a_quiet_drive: assert property (s_quiet |-> bus_out_en_n)
		else $error("drive without strobe");
endmodule // speech_rom_checker
bind speech_rom_address_mux speech_rom_checker checker_i (.sys_clk, .sys_rst, .bus_in,
	.load_high, .load_medium, .data_strobe_pin, .bus_out_en_n, .mem_addr, .card_en,
	.chip_en, .out_en);

// *** verif/rom_chip_model.sv ***
// Memory chip model behind the card decode
// Assumes the card clock; lines float when no output is enabled
`timescale 1ns/1ps
module rom_chip_model import speech_rom_pkg::*; (
	input  wire logic       sys_clk,
	input  wire mem_addr_t  mem_addr,
	input  wire logic [1:0] out_en,
	output bus_byte_t       mem_data
);
	bus_byte_t junk = 8'h5A;
	// Released lines show a changing pattern
	always @(posedge sys_clk)
		junk <= ~junk ^ mem_addr[7:0];
	assign mem_data = |out_en ? mem_addr[7:0] ^ mem_addr[15:8] : junk;
endmodule // rom_chip_model

// *** verif/tb.sv ***
// Self-checking bench for the speech card address logic
// Assumes design, checker and memory model compiled first
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin n_mismatch++; \
	$display("ERROR %s expected %h seen %h", n, e, s); end end
module tb;
	import speech_rom_pkg::*;
	logic       sys_clk = 0, sys_rst = 1, load_high = 0, load_medium = 0, data_strobe_pin = 0;
	logic       card_en, virtual_card, bus_out_en_n, in_range;
	logic [2:0] card_switch = 0, card_id;
	logic [3:0] chip_en, write_en;
	logic [1:0] out_en;
	bus_byte_t  bus_in = 0, bus_out, mem_data;
	mem_addr_t  mem_addr;
	bus_cycle_t last_cycle;
	int         n_mismatch = 0, cmp_count = 0, k;
	mem_addr_t  corner [4] = '{20'h0_0000, 20'h3_FFFF, 20'h4_0000, 20'h2_8000};
	always #4 sys_clk = ~sys_clk;
	speech_rom_address_mux speech_rom_address_mux_i (.sys_clk, .sys_rst, .bus_in, .load_high,
		.load_medium, .data_strobe_pin, .card_switch, .mem_data, .bus_out, .bus_out_en_n,
		.mem_addr, .card_en, .chip_en, .out_en, .write_en, .virtual_card, .card_id, .last_cycle);
	rom_chip_model rom_chip_model_i (.sys_clk, .mem_addr, .out_en, .mem_data);
	function automatic bus_byte_t exp_data(mem_addr_t x);
		return x[7:0] ^ x[15:8];
	endfunction
	task automatic step(int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic close_out;
		$display("Compared %0d, mismatched %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic access(mem_addr_t x);
		in_range = x <= 20'h3_FFFF;
		bus_in = {4'h0, x[19:16]};
		load_high = 1;
		step(1);
		`CHK("high cycle", cyc_high, last_cycle)
		load_high = 0;
		load_medium = 1;
		bus_in = x[15:8];
		step(1);
		load_medium = 0;
		bus_in = x[7:0];
		data_strobe_pin = 1;
		step(1);
		`CHK("address", x, mem_addr)
		`CHK("card enable", in_range, card_en)
		`CHK("virtual card", x[17], virtual_card)
		`CHK("write enable", 4'h0, write_en)
		`CHK("chip enable", (in_range ? (4'h1 << x[16:15]) : 4'h0), chip_en)
		for (k = 0; k < 12 && bus_out_en_n !== 1'b0; k++)
			step(1);
		`CHK("drive", ~in_range, bus_out_en_n)
		if (in_range && bus_out_en_n !== 1'b0)
			close_out();
		if (in_range)
			`CHK("data", exp_data(x), bus_out)
		if (in_range)
			`CHK("data cycle", cyc_data, last_cycle)
		data_strobe_pin = 0;
		for (k = 0; k < 12 && bus_out_en_n !== 1'b1; k++)
			step(1);
		`CHK("release", 1'b1, bus_out_en_n)
	endtask
	initial begin
		void'($urandom(32'he8b0_88af));
		card_switch = 3'($urandom);
		step(8);
		sys_rst = 0;
		step(6);
		`CHK("card id", card_switch, card_id)
		foreach (corner[i])
			access(corner[i]);
		repeat (40)
			access(20'($urandom_range(20'h4_7FFF)));
		close_out();
	end
endmodule // tb
